// *** pkg/extra_dma_pkg.sv ***
package extra_dma_pkg;
    // word indices; byte address is four times the index
    localparam logic [9:0] IDX_CMD          = 10'h064;
    localparam logic [9:0] IDX_STATUS       = 10'h06E;
    localparam logic [9:0] IDX_AUX_BUF_LEN  = 10'h180;
    localparam logic [9:0] IDX_AUX_NOTIFY   = 10'h181;
    localparam logic [9:0] IDX_STAMP_BUFLEN = 10'h182;
    localparam logic [9:0] IDX_STAMP_NOTIFY = 10'h183;
    localparam logic [9:0] IDX_WAIT_TIMEOUT = 10'h184;
    // per stream, element 0 is aux samples, element 1 is timestamps
    localparam logic [1:0][9:0] IDX_USER_LEN = {10'h0DC, 10'h0D2};
    localparam logic [1:0][9:0] IDX_USER_POS = {10'h0DD, 10'h0D3};
    localparam logic [1:0][9:0] IDX_FREED    = {10'h0DE, 10'h0D4};
    localparam logic [1:0][9:0] IDX_BUF_LEN  = {IDX_STAMP_BUFLEN, IDX_AUX_BUF_LEN};
    localparam logic [1:0][9:0] IDX_NOTIFY   = {IDX_STAMP_NOTIFY, IDX_AUX_NOTIFY};
    localparam int BIT_START  = 20;
    localparam int BIT_WAIT   = 21;
    localparam int BIT_STOP   = 22;
    localparam int BIT_POLL   = 23;
    localparam int BIT_BLKRDY = 12;
    localparam int BIT_DONE   = 13;
    localparam int BIT_OVERRN = 14;
    localparam int BIT_ERROR  = 15;
    localparam logic [31:0] EXTRA_STAT_MASK = 32'h0000F000;
    localparam logic        STREAM_AUX      = 1'b0;
    localparam logic        STREAM_STAMP    = 1'b1;
    localparam logic [31:0] BEAT_BYTES      = 32'h00000008;
    localparam int          STAMP_BITS      = 56;
    localparam logic [31:0] RST_BUF_LEN     = 32'h00000000;
    localparam logic [31:0] RST_NOTIFY      = 32'h00000000;
    localparam logic [31:0] RST_TIMEOUT     = 32'h00000000;
    localparam int TIMEOUT_UNIT_NS = 1000000;
    localparam int CLK_PERIOD_NS   = 5;
    localparam int MS_CYCLES       = (TIMEOUT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {MODE_IDLE, MODE_DMA, MODE_POLL} mode_e;

    typedef struct packed {
        mode_e            mode;
        logic             dpValid;
        logic             dpWrite;
        logic             dpExec;
        logic [9:0]       dpIndex;
        logic             waiting;
        logic             pollBusy;
        logic             pollStream;
        logic [31:0]      waitMs;
        logic [31:0]      msCnt;
        logic [31:0]      timeoutMs;
        logic [1:0][31:0] bufLen;
        logic [1:0][31:0] notify;
        logic [1:0][31:0] writePos;
        logic [1:0][31:0] pending;
        logic [1:0][31:0] userLen;
        logic [1:0][31:0] userPos;
        logic [1:0][31:0] cardFree;
        logic             doneF;
        logic             overrunF;
        logic             errorF;
        logic             dmaValid;
        logic             dmaKind;
        logic [31:0]      dmaAddr;
        logic [63:0]      dmaData;
        logic [31:0]      rdata;
        logic [31:0]      mainCmd;
        logic             mainStrobe;
    } state_s;
endpackage : extra_dma_pkg

// *** src/extra_fifo_dma_transfer.sv ***
`timescale 1ns/10ps
// Summary of operation
// - start bit begins ring transfer, DMA mode
// - wait stalls until block, done, overrun, error or timeout
// - stop bit halts transfer, data invalid
// - poll mode moves data only on read
// - one command write acts on all bits
// - block ready once notify block available
// - done flag raised only with notify zero
// - overrun flag on FIFO overflow or underflow while not idle
// - error flag on internal fault
// - engine independent of main sample engine
// - shared FIFO split into two streams
// - notify zero reports only when complete
// - card to host only, no start offset
// - aux stream: length, position, freed counters
// - stamp stream: length, position, freed counters
// - after start: zero available, full free
// - available count moves in notify steps
// - overrun stops the transfer at once
// - poll read reports all fetched, 8-byte grain
// - stamp is 56 bits in 8-byte slot
module extra_fifo_dma_transfer #(
    parameter int MS_CYCLES = extra_dma_pkg::MS_CYCLES
) (
    // clock and control
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // extra FIFO
    input  wire logic        fifoValid,
    input  wire logic        fifoKind,
    input  wire logic [63:0] fifoData,
    output logic             fifoReady,
    input  wire logic        fifoOverflow,
    input  wire logic        fifoUnderflow,
    input  wire logic        internalFault,
    // host memory writes
    output logic             dmaValid,
    input  wire logic        dmaReady,
    output logic             dmaKind,
    output logic [31:0]      dmaAddr,
    output logic [63:0]      dmaData,
    // shared command and status with the rest of the card
    output logic [31:0]      mainCmd,
    output logic             mainCmdStrobe,
    input  wire logic [31:0] mainStatus
);
    extra_dma_pkg::state_s st_r;
    extra_dma_pkg::state_s st_nxt;

    logic        waitNow;
    logic        blockReady;
    logic        engineOn;
    logic        outFree;
    logic        take;
    logic        execCmd;
    logic        waitEnd;
    logic [31:0] dec;

    function automatic logic [31:0] wrapAdd(input logic [31:0] pos, input logic [31:0] inc,
                                            input logic [31:0] len);
        logic [32:0] sum;
        sum = {1'b0, pos} + {1'b0, inc};
        if (len == 32'h00000000)
            wrapAdd = 32'h00000000;
        else if (sum >= {1'b0, len})
            wrapAdd = 32'(sum - {1'b0, len});
        else
            wrapAdd = sum[31:0];
    endfunction : wrapAdd

    always_comb
    begin
        blockReady = 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            if (st_r.notify[s] != 32'h00000000 && st_r.userLen[s] >= st_r.notify[s])
                blockReady = 1'b1;
        end
    end

    assign execCmd = st_r.dpValid && st_r.dpWrite && !st_r.dpExec
                     && st_r.dpIndex == extra_dma_pkg::IDX_CMD;
    // a wait only blocks when the same write leaves the engine in DMA mode
    assign waitNow = execCmd && hwdata[extra_dma_pkg::BIT_WAIT] && !hwdata[extra_dma_pkg::BIT_POLL]
                     && (hwdata[extra_dma_pkg::BIT_START]
                         || (st_r.mode == extra_dma_pkg::MODE_DMA
                             && !hwdata[extra_dma_pkg::BIT_STOP]));
    // a frozen engine must not finish a bus transfer it cannot register
    assign hreadyout = ce && !(st_r.waiting || st_r.pollBusy || waitNow);
    assign hresp     = 1'b0;
    assign waitEnd   = blockReady || st_r.doneF || st_r.overrunF || st_r.errorF
                       || st_r.mode != extra_dma_pkg::MODE_DMA
                       || (st_r.timeoutMs != 32'h00000000 && st_r.waitMs >= st_r.timeoutMs);

    // this engine has its own FIFO, beat port and counters
    assign engineOn = st_r.mode == extra_dma_pkg::MODE_DMA
                      || (st_r.mode == extra_dma_pkg::MODE_POLL && st_r.pollBusy);
    assign outFree  = !st_r.dmaValid || dmaReady;
    // no pop while frozen, or the record would be lost
    assign take     = ce && engineOn && fifoValid && outFree
                      && st_r.cardFree[fifoKind] >= extra_dma_pkg::BEAT_BYTES;
    assign fifoReady = take;

    always_comb
    begin
        st_nxt = st_r;
        dec = 32'h00000000;
        st_nxt.mainStrobe = 1'b0;
        if (st_r.dmaValid && dmaReady)
            st_nxt.dmaValid = 1'b0;
        // move one record into the ring of its own stream
        if (take)
        begin
            st_nxt.dmaValid = 1'b1;
            st_nxt.dmaKind  = fifoKind;
            st_nxt.dmaAddr  = st_r.writePos[fifoKind];
            if (fifoKind == extra_dma_pkg::STREAM_STAMP)
                st_nxt.dmaData = {8'h00, fifoData[extra_dma_pkg::STAMP_BITS-1:0]};
            else
                st_nxt.dmaData = fifoData;
            st_nxt.writePos[fifoKind] = wrapAdd(st_r.writePos[fifoKind],
                                                extra_dma_pkg::BEAT_BYTES,
                                                st_r.bufLen[fifoKind]);
            st_nxt.cardFree[fifoKind] = st_r.cardFree[fifoKind] - extra_dma_pkg::BEAT_BYTES;
            st_nxt.pending[fifoKind]  = st_r.pending[fifoKind] + extra_dma_pkg::BEAT_BYTES;
        end
        // announce transferred bytes to the host
        if (st_r.mode == extra_dma_pkg::MODE_DMA)
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (st_r.notify[s] != 32'h00000000)
                begin
                    if (st_nxt.pending[s] >= st_r.notify[s])
                    begin
                        st_nxt.pending[s] = st_nxt.pending[s] - st_r.notify[s];
                        st_nxt.userLen[s] = st_nxt.userLen[s] + st_r.notify[s];
                    end
                end
                else if (st_nxt.cardFree[s] == 32'h00000000 && st_nxt.pending[s] != 32'h00000000)
                begin
                    st_nxt.userLen[s] = st_nxt.userLen[s] + st_nxt.pending[s];
                    st_nxt.pending[s] = 32'h00000000;
                    st_nxt.doneF      = 1'b1;
                end
            end
        end
        // poll fetch ends once nothing more can move
        if (st_r.pollBusy && !take && !st_r.dmaValid)
        begin
            for (int s = 0; s < 2; s++)
            begin
                st_nxt.userLen[s] = st_nxt.userLen[s] + st_nxt.pending[s];
                st_nxt.pending[s] = 32'h00000000;
            end
            st_nxt.rdata    = st_nxt.userLen[st_r.pollStream];
            st_nxt.pollBusy = 1'b0;
        end
        // wait timer in whole milliseconds
        if (st_r.waiting)
        begin
            if (st_r.msCnt == 32'(MS_CYCLES - 1))
            begin
                st_nxt.msCnt  = 32'h00000000;
                st_nxt.waitMs = st_r.waitMs + 32'h00000001;
            end
            else
                st_nxt.msCnt = st_r.msCnt + 32'h00000001;
            if (waitEnd)
                st_nxt.waiting = 1'b0;
        end
        // register writes in the data phase
        if (st_r.dpValid && st_r.dpWrite && !st_r.dpExec)
        begin
            st_nxt.dpExec = 1'b1;
            if (execCmd)
            begin
                st_nxt.mainCmd    = hwdata;
                st_nxt.mainStrobe = 1'b1;
                if (hwdata[extra_dma_pkg::BIT_STOP])
                    st_nxt.mode = extra_dma_pkg::MODE_IDLE;
                if (hwdata[extra_dma_pkg::BIT_START] || hwdata[extra_dma_pkg::BIT_POLL])
                begin
                    // buffer length and notify are taken as already defined
                    for (int s = 0; s < 2; s++)
                    begin
                        st_nxt.writePos[s] = 32'h00000000;
                        st_nxt.pending[s]  = 32'h00000000;
                        st_nxt.userLen[s]  = 32'h00000000;
                        st_nxt.userPos[s]  = 32'h00000000;
                        st_nxt.cardFree[s] = st_r.bufLen[s];
                    end
                    st_nxt.doneF    = 1'b0;
                    st_nxt.overrunF = 1'b0;
                    st_nxt.errorF   = 1'b0;
                    st_nxt.dmaValid = 1'b0;
                    st_nxt.mode     = hwdata[extra_dma_pkg::BIT_POLL]
                                      ? extra_dma_pkg::MODE_POLL : extra_dma_pkg::MODE_DMA;
                end
                if (waitNow)
                begin
                    st_nxt.waiting = 1'b1;
                    st_nxt.waitMs  = 32'h00000000;
                    st_nxt.msCnt   = 32'h00000000;
                end
            end
            for (int s = 0; s < 2; s++)
            begin
                if (st_r.dpIndex == extra_dma_pkg::IDX_FREED[s])
                begin
                    // freed bytes go back to the card
                    dec = (hwdata > st_nxt.userLen[s]) ? st_nxt.userLen[s] : hwdata;
                    if (hwdata > st_nxt.userLen[s])
                        st_nxt.errorF = 1'b1;
                    st_nxt.userLen[s]  = st_nxt.userLen[s] - dec;
                    st_nxt.userPos[s]  = wrapAdd(st_r.userPos[s], dec, st_r.bufLen[s]);
                    st_nxt.cardFree[s] = st_nxt.cardFree[s] + dec;
                end
                if (st_r.dpIndex == extra_dma_pkg::IDX_BUF_LEN[s])
                    st_nxt.bufLen[s] = hwdata;
                if (st_r.dpIndex == extra_dma_pkg::IDX_NOTIFY[s])
                    st_nxt.notify[s] = hwdata;
            end
            if (st_r.dpIndex == extra_dma_pkg::IDX_WAIT_TIMEOUT)
                st_nxt.timeoutMs = hwdata;
        end
        // hardware faults win over a clearing start, except an overrun on an idle engine
        if (st_r.mode != extra_dma_pkg::MODE_IDLE && (fifoOverflow || fifoUnderflow))
        begin
            st_nxt.overrunF = 1'b1;
            st_nxt.mode     = extra_dma_pkg::MODE_IDLE;
        end
        if (internalFault)
            st_nxt.errorF = 1'b1;
        // address phase
        if (hsel && htrans[1] && hready)
        begin
            st_nxt.dpValid = 1'b1;
            st_nxt.dpWrite = hwrite;
            st_nxt.dpExec  = 1'b0;
            st_nxt.dpIndex = haddr[11:2];
            if (!hwrite)
            begin
                st_nxt.rdata = 32'h00000000;
                if (haddr[11:2] == extra_dma_pkg::IDX_STATUS)
                    st_nxt.rdata = (mainStatus & ~extra_dma_pkg::EXTRA_STAT_MASK)
                                   | (32'(blockReady) << extra_dma_pkg::BIT_BLKRDY)
                                   | (32'(st_r.doneF) << extra_dma_pkg::BIT_DONE)
                                   | (32'(st_r.overrunF) << extra_dma_pkg::BIT_OVERRN)
                                   | (32'(st_r.errorF) << extra_dma_pkg::BIT_ERROR);
                if (haddr[11:2] == extra_dma_pkg::IDX_WAIT_TIMEOUT)
                    st_nxt.rdata = st_r.timeoutMs;
                for (int s = 0; s < 2; s++)
                begin
                    if (haddr[11:2] == extra_dma_pkg::IDX_USER_LEN[s])
                    begin
                        st_nxt.rdata = st_r.userLen[s];
                        if (st_r.mode == extra_dma_pkg::MODE_POLL)
                        begin
                            st_nxt.pollBusy   = 1'b1;
                            st_nxt.pollStream = s[0];
                        end
                    end
                    if (haddr[11:2] == extra_dma_pkg::IDX_USER_POS[s])
                        st_nxt.rdata = st_r.userPos[s];
                    if (haddr[11:2] == extra_dma_pkg::IDX_BUF_LEN[s])
                        st_nxt.rdata = st_r.bufLen[s];
                    if (haddr[11:2] == extra_dma_pkg::IDX_NOTIFY[s])
                        st_nxt.rdata = st_r.notify[s];
                end
            end
        end
        else if (hreadyout)
            st_nxt.dpValid = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_r           <= '0;
            st_r.mode      <= extra_dma_pkg::MODE_IDLE;
            st_r.bufLen    <= {extra_dma_pkg::RST_BUF_LEN, extra_dma_pkg::RST_BUF_LEN};
            st_r.notify    <= {extra_dma_pkg::RST_NOTIFY, extra_dma_pkg::RST_NOTIFY};
            st_r.timeoutMs <= extra_dma_pkg::RST_TIMEOUT;
        end
        else if (ce)
            st_r <= st_nxt;
    end

    assign hrdata        = st_r.rdata;
    assign dmaValid      = st_r.dmaValid;
    assign dmaKind       = st_r.dmaKind;
    assign dmaAddr       = st_r.dmaAddr;
    assign dmaData       = st_r.dmaData;
    assign mainCmd       = st_r.mainCmd;
    assign mainCmdStrobe = st_r.mainStrobe;

    logic execStart;
    assign execStart = ce && execCmd && hwdata[extra_dma_pkg::BIT_START]
                       && !hwdata[extra_dma_pkg::BIT_POLL] && !fifoOverflow && !fifoUnderflow;

    AST_START_CLEARS: assert property (@(posedge clock) disable iff (srst)
        execStart |=> st_r.userLen[0] == 32'h00000000 && st_r.cardFree[1] == st_r.bufLen[1]
                      && st_r.mode == extra_dma_pkg::MODE_DMA)
        else $error("start did not clear stream counters");
    AST_WAIT_HOLDS: assert property (@(posedge clock) disable iff (srst)
        ce && st_r.waiting && !waitEnd |=> !hreadyout)
        else $error("bus released while wait pending");
    AST_STOP_IDLE: assert property (@(posedge clock) disable iff (srst)
        ce && execCmd && hwdata[extra_dma_pkg::BIT_STOP] && !hwdata[extra_dma_pkg::BIT_START]
        && !hwdata[extra_dma_pkg::BIT_POLL] |=> st_r.mode == extra_dma_pkg::MODE_IDLE)
        else $error("stop left engine running");
    AST_POLL_NO_DMA: assert property (@(posedge clock) disable iff (srst)
        st_r.mode == extra_dma_pkg::MODE_POLL && !st_r.pollBusy |-> !fifoReady)
        else $error("poll mode moved data unrequested");
    AST_OVERRUN_STOPS: assert property (@(posedge clock) disable iff (srst)
        ce && st_r.mode != extra_dma_pkg::MODE_IDLE && fifoOverflow
        |=> st_r.overrunF && st_r.mode == extra_dma_pkg::MODE_IDLE)
        else $error("overrun did not stop transfer");
    AST_NOTIFY_STEP: assert property (@(posedge clock) disable iff (srst)
        ce && st_r.mode == extra_dma_pkg::MODE_DMA && st_r.notify[0] != 32'h00000000
        && st_nxt.userLen[0] > st_r.userLen[0]
        |=> st_r.userLen[0] == $past(st_r.userLen[0]) + $past(st_r.notify[0]))
        else $error("available count moved off notify step");
    AST_DONE_ZERO: assert property (@(posedge clock) disable iff (srst)
        $rose(st_r.doneF) |-> st_r.notify[0] == 32'h00000000 || st_r.notify[1] == 32'h00000000)
        else $error("done raised with nonzero notify");
    AST_RING_BOUND: assert property (@(posedge clock) disable iff (srst)
        st_r.dmaValid |-> st_r.dmaAddr < st_r.bufLen[st_r.dmaKind])
        else $error("ring write outside buffer");
    AST_STAMP_PAD: assert property (@(posedge clock) disable iff (srst)
        st_r.dmaValid && st_r.dmaKind == extra_dma_pkg::STREAM_STAMP |-> st_r.dmaData[63:56] == 8'h00)
        else $error("stamp slot not padded");
    AST_ERROR_SET: assert property (@(posedge clock) disable iff (srst)
        ce && internalFault |=> st_r.errorF)
        else $error("internal fault lost");
    AST_CMD_PASS: assert property (@(posedge clock) disable iff (srst)
        ce && execCmd |=> mainCmdStrobe && mainCmd == $past(hwdata))
        else $error("command not forwarded");

    COV_START: cover property (@(posedge clock) disable iff (srst) execStart);
    COV_WAIT_DONE: cover property (@(posedge clock) disable iff (srst) $fell(st_r.waiting));
    COV_POLL_DONE: cover property (@(posedge clock) disable iff (srst) $fell(st_r.pollBusy));
    COV_DONE: cover property (@(posedge clock) disable iff (srst) $rose(st_r.doneF));
endmodule : extra_fifo_dma_transfer

// *** tb/host_memory_model.sv ***
`timescale 1ns/10ps
module host_memory_model #(
    parameter int          SLOW    = 1,
    parameter logic [31:0] AUX_LEN = 32'h00000020,
    parameter logic [31:0] TS_LEN  = 32'h00000020
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // host write beats
    input  wire logic        dmaValid,
    output logic             dmaReady,
    input  wire logic        dmaKind,
    input  wire logic [31:0] dmaAddr,
    input  wire logic [63:0] dmaData,
    // command watch
    input  wire logic [31:0] mainCmd,
    input  wire logic        mainCmdStrobe,
    // results
    output int               beats,
    output int               faults
);
    logic [1:0]       tick;
    logic [1:0][31:0] nextAddr;
    logic [31:0]      lim;
    // the host stalls half the time
    assign dmaReady = (SLOW == 0) || tick[1];
    assign lim = dmaKind ? TS_LEN : AUX_LEN;
    always @(posedge clock)
    begin
        tick <= tick + 2'h1;
        if (srst)
        begin
            tick <= 2'h0;
            beats <= 0;
            faults <= 0;
            nextAddr <= '0;
        end
        else if (mainCmdStrobe && (mainCmd[extra_dma_pkg::BIT_START] || mainCmd[extra_dma_pkg::BIT_POLL]))
        begin
            nextAddr <= '0;
        end
        else if (dmaValid && dmaReady)
        begin
            beats <= beats + 1;
            if (dmaAddr !== nextAddr[dmaKind] || (dmaKind && dmaData[63:56] !== 8'h00))
                faults <= faults + 1;
            nextAddr[dmaKind] <= (dmaAddr + 32'h8 == lim) ? 32'h0 : dmaAddr + 32'h8;
        end
    end
endmodule : host_memory_model

// *** tb/tb_extra_fifo_dma_transfer.sv ***
`timescale 1ns/10ps
module tb_extra_fifo_dma_transfer;
    logic        clock, srst, hsel, hwrite, fifoKind, fifoOverflow, fifoUnderflow, internalFault;
    logic        hreadyout, hresp, fifoValid, fifoReady, dmaValid, dmaReady, dmaKind, mainCmdStrobe;
    logic [31:0] haddr, hwdata, hrdata, dmaAddr, mainCmd, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [63:0] dmaData;
    int          errorCnt, nChecks, pend, addN, stall, beats, faults;

    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    // record source: pend records wait in the extra FIFO
    assign fifoValid = pend != 0;
    always @(posedge clock) pend <= srst ? 0 : pend + addN - int'(fifoValid && fifoReady);

    extra_fifo_dma_transfer #(.MS_CYCLES(4)) i_extra_fifo_dma_transfer (
        .clock(clock), .srst(srst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fifoValid(fifoValid),
        .fifoKind(fifoKind), .fifoData(64'hFFEEDDCCBBAA9988), .fifoReady(fifoReady),
        .fifoOverflow(fifoOverflow), .fifoUnderflow(fifoUnderflow),
        .internalFault(internalFault), .dmaValid(dmaValid), .dmaReady(dmaReady),
        .dmaKind(dmaKind), .dmaAddr(dmaAddr), .dmaData(dmaData), .mainCmd(mainCmd),
        .mainCmdStrobe(mainCmdStrobe), .mainStatus(32'h0000F005));

    host_memory_model i_host_memory_model (
        .clock(clock), .srst(srst), .dmaValid(dmaValid), .dmaReady(dmaReady),
        .dmaKind(dmaKind), .dmaAddr(dmaAddr), .dmaData(dmaData), .mainCmd(mainCmd),
        .mainCmdStrobe(mainCmdStrobe), .beats(beats), .faults(faults));

    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic timeout();
        errorCnt++;
        $display("mismatch at %0t: wait limit used up", $time);
        conclude();
    endtask : timeout

    // one AHB-Lite single word transfer; stall counts data-phase wait cycles
    task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0, idx, 2'b00};
        do begin @(posedge clock); if (++k > 3000) timeout(); end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        stall = -1;
        do begin @(posedge clock); stall++; if (++k > 3000) timeout(); end while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic push(input logic kind, input int n, input logic drain);
        int k;
        k = 0;
        fifoKind <= kind;
        addN <= n;
        @(posedge clock);
        addN <= 0;
        if (drain)
            do begin @(posedge clock); if (++k > 3000) timeout(); end while (pend != 0 || dmaValid !== 1'b0);
    endtask : push

    task automatic pulse(input int which);
        if (which == 0) fifoOverflow <= 1'b1;
        if (which == 1) fifoUnderflow <= 1'b1;
        if (which == 2) internalFault <= 1'b1;
        @(posedge clock);
        {fifoOverflow, fifoUnderflow, internalFault} <= 3'b000;
        repeat (4) @(posedge clock);
    endtask : pulse

    initial
    begin
        {srst, hsel, hwrite, fifoKind, fifoOverflow, fifoUnderflow, internalFault} = 7'h40;
        {haddr, hwdata, htrans, addN, errorCnt, nChecks} = '0;
        hsize = 3'b010;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        bus(1'b1, extra_dma_pkg::IDX_BUF_LEN[0], 32'h00000020);
        bus(1'b1, extra_dma_pkg::IDX_NOTIFY[0], 32'h00000010);
        bus(1'b1, extra_dma_pkg::IDX_BUF_LEN[1], 32'h00000020);
        bus(1'b1, extra_dma_pkg::IDX_NOTIFY[1], 32'h00000000);
        bus(1'b1, extra_dma_pkg::IDX_WAIT_TIMEOUT, 32'h00000002);
        bus(1'b1, extra_dma_pkg::IDX_CMD, 32'h00100004);
        @(posedge clock);
        chk(mainCmd, 32'h00100004);
        bus(1'b0, extra_dma_pkg::IDX_USER_LEN[0], 32'h0);
        chk(rd, 32'h00000000);
        $display("test start done");
        bus(1'b1, extra_dma_pkg::IDX_CMD, 32'h00200000);
        chk(32'(stall >= 7 && stall <= 10), 32'h00000001);
        bus(1'b1, extra_dma_pkg::IDX_WAIT_TIMEOUT, 32'h00000000);
        fork
            bus(1'b1, extra_dma_pkg::IDX_CMD, 32'h00200000);
            push(1'b0, 2, 1'b1);
        join
        bus(1'b0, extra_dma_pkg::IDX_USER_LEN[0], 32'h0);
        chk(rd, 32'h00000010);
        bus(1'b0, extra_dma_pkg::IDX_STATUS, 32'h0);
        chk(rd, 32'h00001005);
        push(1'b0, 1, 1'b1);
        bus(1'b0, extra_dma_pkg::IDX_USER_LEN[0], 32'h0);
        chk(rd, 32'h00000010);
        $display("test wait and notify done");
        push(1'b1, 4, 1'b1);
        bus(1'b0, extra_dma_pkg::IDX_STATUS, 32'h0);
        chk(rd & 32'h00002000, 32'h00002000);
        bus(1'b0, extra_dma_pkg::IDX_USER_LEN[1], 32'h0);
        chk(rd, 32'h00000020);
        bus(1'b1, extra_dma_pkg::IDX_FREED[0], 32'h00000010);
        bus(1'b0, extra_dma_pkg::IDX_USER_POS[0], 32'h0);
        chk(rd, 32'h00000010);
        $display("test streams done");
        pulse(0);
        push(1'b0, 1, 1'b0);
        repeat (6) @(posedge clock);
        chk(32'(beats), 32'h00000007);
        pulse(2);
        bus(1'b0, extra_dma_pkg::IDX_STATUS, 32'h0);
        chk(rd & 32'h0000C000, 32'h0000C000);
        $display("test faults done");
        bus(1'b1, extra_dma_pkg::IDX_CMD, 32'h00800000);
        bus(1'b0, extra_dma_pkg::IDX_STATUS, 32'h0);
        chk(rd, 32'h00000005);
        bus(1'b0, extra_dma_pkg::IDX_USER_LEN[0], 32'h0);
        chk(rd, 32'h00000008);
        pulse(1);
        bus(1'b0, extra_dma_pkg::IDX_STATUS, 32'h0);
        chk(rd & 32'h00004000, 32'h00004000);
        bus(1'b1, extra_dma_pkg::IDX_CMD, 32'h00100000);
        bus(1'b1, extra_dma_pkg::IDX_CMD, 32'h00600000);
        chk(32'(stall), 32'h00000000);
        push(1'b0, 1, 1'b0);
        repeat (6) @(posedge clock);
        chk(32'(beats), 32'h00000008);
        bus(1'b0, 10'h3FF, 32'h0);
        chk(rd, 32'h00000000);
        chk(32'(faults), 32'h00000000);
        $display("test poll and stop done");
        conclude();
    end
endmodule : tb_extra_fifo_dma_transfer
